// file: rtl/cdb_cfg.svh
// Offsets, field positions and constants of the decimal, bit and MAC unit.
// Overview of operation
// [RULE1] bcd_subtract: packed BCD dest minus src, carry ignored, byte or word.
// [RULE2] bcd_subtract_with_borrow: same, also subtracting the borrow held in carry.
// [RULE3] Both decimal subtracts update sign, zero and carry from the result.
// [RULE4] add_imm_branch_nonzero: dest plus immediate, stored; branch when nonzero.
// [RULE5] sub_imm_branch_nonzero: dest minus immediate, stored; branch when nonzero.
// [RULE6] Immediate is 4 bits: -8..+7 for add, -7..+8 for subtract.
// [RULE7] Branch target is PC relative, -126..+129 from instruction start.
// [RULE8] sum_of_products multiplies through both pointers, count sets iterations.
// [RULE9] Byte-size sum_of_products keeps its sum in low_accumulator.
// [RULE10] Accumulation overflow sets overflow flag, then ends the operation.
// [RULE11] That overflow also raises an overflow interrupt request.
// [RULE12] Interrupt mid-run: finish addition, decrement count, then accept it.
// [RULE13] Sign extension copies the sign bit into upper bits, byte or word.
// [RULE14] Word sign extension widens low_accumulator to 32 bits over the pair.
// [RULE15] Bit AND/OR, plain or inverted bit, with carry, result to carry.
// [RULE16] Bit XOR puts bit XOR carry into carry; inverted form uses complement.
// [RULE17] conditional_bit_transfer writes 1 when condition true, 0 when false.
// [RULE18] Unsigned conditions: C; C and not Z; not C; not C or Z.
// [RULE19] Signed conditions compare sign with overflow, with zero where needed.
// [RULE20] Single-flag conditions test zero, sign or overflow directly.
// [RULE21] Decimal subtract borrows digit to digit, corrects digits to 0..9.
`ifndef CDB_CFG_SVH
`define CDB_CFG_SVH
`define CDB_OFS_CTRL  8'h00
`define CDB_OFS_OPA   8'h04
`define CDB_OFS_OPB   8'h08
`define CDB_OFS_FLAGS 8'h0c
`define CDB_OFS_HIGH  8'h10
`define CDB_OFS_PC    8'h14
`define CDB_OFS_DISP  8'h18
`define CDB_OFS_MCAND 8'h1c
`define CDB_OFS_MPLR  8'h20
`define CDB_OFS_COUNT 8'h24
`define CDB_OFS_STAT  8'h28
`define CDB_MEM_SEL   2'h1
`define CDB_OP_LO     0
`define CDB_WORD_BIT  4
`define CDB_TOC_BIT   5
`define CDB_IMM_LO    8
`define CDB_COND_LO   12
`define CDB_BIT_LO    16
`define CDB_GO_BIT    31
`define CDB_FL_C      0
`define CDB_FL_Z      1
`define CDB_FL_S      2
`define CDB_FL_O      3
`define CDB_BR_BIAS   16'h0002
`define CDB_SUB_EIGHT 4'h8
`endif

// file: rtl/cdb_pkg.sv
// Types shared by the decimal, bit and MAC unit.
package cdb_pkg;
  typedef enum logic [3:0] {
    OP_BCD_SUBTRACT    = 4'h0, OP_BCD_SUBTRACT_WITH_BORROW = 4'h1,
    OP_ADD_IMM_BRANCH  = 4'h2, OP_SUB_IMM_BRANCH = 4'h3,
    OP_SUM_OF_PRODUCTS = 4'h4, OP_SIGN_EXTEND    = 4'h5,
    OP_BIT_AND_CARRY   = 4'h6, OP_BIT_INV_AND_CARRY = 4'h7,
    OP_BIT_OR_CARRY    = 4'h8, OP_BIT_INV_OR_CARRY  = 4'h9,
    OP_BIT_XOR_CARRY   = 4'ha, OP_BIT_INV_XOR_CARRY = 4'hb,
    OP_CONDITIONAL_BIT_TRANSFER = 4'hc
  } cdb_op_e;
  typedef enum logic [3:0] {
    UNSIGNED_AT_LEAST = 4'h0, UNSIGNED_ABOVE   = 4'h1,
    EQUAL_COND        = 4'h2, NEGATIVE_COND    = 4'h3,
    SIGNED_AT_MOST    = 4'h4, OVERFLOW_COND    = 4'h5,
    SIGNED_AT_LEAST   = 4'h6, UNSIGNED_UNDER   = 4'h7,
    UNSIGNED_AT_MOST  = 4'h8, UNEQUAL_COND     = 4'h9,
    NONNEGATIVE_COND  = 4'ha, SIGNED_ABOVE     = 4'hb,
    NO_OVERFLOW_COND  = 4'hc, SIGNED_UNDER     = 4'hd
  } cdb_cond_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00, ST_RUN = 2'b01, ST_END = 2'b11
  } cdb_state_e;
endpackage

// file: rtl/cdb_exec.sv
// Decimal subtract, branch-count, sum-of-products and bit unit, APB slave.
//
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "cdb_cfg.svh"
module cdb_exec
  import cdb_pkg::*;
#(
  parameter int MAW = 4 // Operand memory address width.
) (
  input  wire logic        clock,     // 10 MHz core clock.
  input  wire logic        rst_n,     // Synchronous reset.
  input  wire logic        psel,      // APB select.
  input  wire logic        penable,   // APB enable.
  input  wire logic        pwrite,    // APB write.
  input  wire logic [7:0]  paddr,     // APB byte address.
  input  wire logic [31:0] pwdata,    // APB write data.
  input  wire logic        irqReq,    // Interrupt pending in core.
  output logic      [31:0] prdata,    // APB read data.
  output logic             pready,    // APB ready.
  output logic             pslverr,   // APB error.
  output logic             busy,      // Operation in progress.
  output logic             ovfIrq,    // Overflow interrupt pulse.
  output logic             irqAccept  // Run paused for interrupt.
);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [21:0]  ctrl_r;
  logic [15:0]  opA_r, opA_nxt;
  logic [15:0]  high_r, high_nxt;
  logic [15:0]  opB_r;
  logic [3:0]   flags_r, flags_nxt;
  logic [15:0]  pc_r, pc_nxt;
  logic [7:0]   disp_r;
  logic [15:0]  mcand_r, mplr_r, count_r;
  logic         exec_r, taken_r, paused_r;
  logic         stepOvf, stepLast;
  logic [15:0]  mem [2**MAW];
  cdb_state_e   state_r;

  cdb_op_e      op;
  cdb_cond_e    cond;
  logic         wsz, toC, curBit, condT, stepping;
  logic [3:0]   imm;
  logic [3:0]   bitSel;
  logic         apbWr, apbSetup;

  assign op     = cdb_op_e'(ctrl_r[`CDB_OP_LO +: 4]);
  assign wsz    = ctrl_r[`CDB_WORD_BIT];
  assign toC    = ctrl_r[`CDB_TOC_BIT];
  assign imm    = ctrl_r[`CDB_IMM_LO +: 4];
  assign cond   = cdb_cond_e'(ctrl_r[`CDB_COND_LO +: 4]);
  assign bitSel = ctrl_r[`CDB_BIT_LO +: 4];
  assign curBit = opB_r[bitSel];
  assign apbWr  = psel & penable & pready & pwrite;
  assign apbSetup = psel & ~penable;
  assign stepping = (state_r == ST_RUN);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Returns {borrow out, digits}; a byte takes its borrow out after two digits.
  function automatic logic [16:0] bcdSub(
    input logic [15:0] a,
    input logic [15:0] b,
    input logic        bin,
    input logic        w
  );
    logic [4:0]  d;
    logic [15:0] r;
    logic        br;
    logic        bo;
    br = bin;
    bo = 1'b0;
    r  = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      d  = {1'b0, a[4*i +: 4]} - {1'b0, b[4*i +: 4]} - {4'h0, br}; // RULE21
      br = d[4];
      r[4*i +: 4] = br ? d[3:0] + 4'ha : d[3:0]; // RULE21
      if (i == 1 && !w) begin
        bo = br;
      end
    end
    if (w) begin
      bo = br;
    end
    return {bo, r};
  endfunction

  function automatic logic condEval(input cdb_cond_e c,
                                    input logic [3:0] f);
    logic cf, zf, sf, of;
    cf = f[`CDB_FL_C];
    zf = f[`CDB_FL_Z];
    sf = f[`CDB_FL_S];
    of = f[`CDB_FL_O];
    case (c)
      UNSIGNED_AT_LEAST: return cf;                  // RULE18
      UNSIGNED_ABOVE:    return cf & ~zf;            // RULE18
      UNSIGNED_UNDER:    return ~cf;                 // RULE18
      UNSIGNED_AT_MOST:  return ~cf | zf;            // RULE18
      SIGNED_AT_LEAST:   return sf == of;            // RULE19
      SIGNED_UNDER:      return sf != of;            // RULE19
      SIGNED_ABOVE:      return (sf == of) & ~zf;    // RULE19
      SIGNED_AT_MOST:    return zf | (sf != of);     // RULE19
      EQUAL_COND:        return zf;                  // RULE20
      UNEQUAL_COND:      return ~zf;                 // RULE20
      NEGATIVE_COND:     return sf;                  // RULE20
      NONNEGATIVE_COND:  return ~sf;                 // RULE20
      OVERFLOW_COND:     return of;                  // RULE20
      NO_OVERFLOW_COND:  return ~of;                 // RULE20
      default:           return 1'b0;
    endcase
  endfunction

  assign condT = condEval(cond, flags_r);

  // ----------------------------------------------------------------
  // Sum-of-products step
  // ----------------------------------------------------------------
  logic [15:0] mA, mB;
  logic [31:0] prod, accOld, accNew;
  logic [32:0] accSum;
  logic [15:0] prodB;

  // The byte product is sign-extended from its own top bit so that a zero
  // product never picks up a stray upper half.
  assign prodB = 16'($signed(mA[7:0]) * $signed(mB[7:0]));

  assign mA = mem[mcand_r[MAW-1:0]];
  assign mB = mem[mplr_r[MAW-1:0]];

  always_comb begin
    if (wsz) begin
      prod   = 32'($signed(mA) * $signed(mB));
      accOld = {high_r, opA_r};
    end else begin
      prod   = {{16{prodB[15]}}, prodB};
      accOld = {{16{opA_r[15]}}, opA_r}; // RULE9
    end
    accSum = {accOld[31], accOld} + {prod[31], prod}; // RULE8
    accNew = accSum[31:0];
    if (wsz) begin
      stepOvf = accSum[32] != accSum[31]; // RULE10
    end else begin
      stepOvf = accSum[16] != accSum[15]; // RULE10
    end
    stepLast = (count_r == 16'h0001);
  end

  // ----------------------------------------------------------------
  // Single-cycle results
  // ----------------------------------------------------------------
  logic [16:0] bcdRes;
  logic [15:0] immS, brRes, resVal;
  logic        resZero, bitOut;

  assign immS = {{12{imm[3]}}, imm}; // RULE6

  always_comb begin
    bcdRes = bcdSub(opA_r, opB_r,
                    (op == OP_BCD_SUBTRACT_WITH_BORROW) &
                    ~flags_r[`CDB_FL_C], wsz); // RULE1 RULE2
    if (op == OP_SUB_IMM_BRANCH) begin
      // The subtract form reads field 8 as +8 instead of -8.
      brRes = opA_r - ((imm == `CDB_SUB_EIGHT) ?
                       16'h0008 : immS); // RULE5 RULE6
    end else begin
      brRes = opA_r + immS; // RULE4
    end
    if (op == OP_ADD_IMM_BRANCH || op == OP_SUB_IMM_BRANCH) begin
      resVal = brRes;
    end else begin
      resVal = bcdRes[15:0];
    end
    resZero = wsz ? (resVal == 16'h0000) : (resVal[7:0] == 8'h00);
    case (op)
      OP_BIT_AND_CARRY:     bitOut = curBit & flags_r[`CDB_FL_C];
      OP_BIT_INV_AND_CARRY: bitOut = ~curBit & flags_r[`CDB_FL_C];
      OP_BIT_OR_CARRY:      bitOut = curBit | flags_r[`CDB_FL_C];
      OP_BIT_INV_OR_CARRY:  bitOut = ~curBit | flags_r[`CDB_FL_C];
      OP_BIT_XOR_CARRY:     bitOut = curBit ^ flags_r[`CDB_FL_C];
      OP_BIT_INV_XOR_CARRY: bitOut = ~curBit ^ flags_r[`CDB_FL_C];
      default:              bitOut = condT;
    endcase
  end

  // ----------------------------------------------------------------
  // Next values of the architectural registers
  // ----------------------------------------------------------------
  always_comb begin
    opA_nxt   = opA_r;
    high_nxt  = high_r;
    flags_nxt = flags_r;
    pc_nxt    = pc_r;
    if (exec_r) begin
      case (op)
        OP_BCD_SUBTRACT, OP_BCD_SUBTRACT_WITH_BORROW: begin
          opA_nxt = wsz ? resVal : {opA_r[15:8], resVal[7:0]}; // RULE1
          flags_nxt[`CDB_FL_C] = ~bcdRes[16]; // RULE3
          flags_nxt[`CDB_FL_Z] = resZero; // RULE3
          flags_nxt[`CDB_FL_S] = wsz ? resVal[15] : resVal[7]; // RULE3
        end
        OP_ADD_IMM_BRANCH, OP_SUB_IMM_BRANCH: begin
          opA_nxt = wsz ? resVal : {opA_r[15:8], resVal[7:0]};
          if (!resZero) begin
            pc_nxt = pc_r + {{8{disp_r[7]}}, disp_r}
                     + `CDB_BR_BIAS; // RULE4 RULE5 RULE7
          end
        end
        OP_SUM_OF_PRODUCTS: begin
          flags_nxt[`CDB_FL_O] = 1'b0;
        end
        OP_SIGN_EXTEND: begin
          if (wsz) begin
            high_nxt = {16{opA_r[15]}}; // RULE13 RULE14
          end else begin
            opA_nxt = {{8{opA_r[7]}}, opA_r[7:0]}; // RULE13
          end
        end
        OP_CONDITIONAL_BIT_TRANSFER: begin
          if (toC) begin
            flags_nxt[`CDB_FL_C] = condT; // RULE17
          end else begin
            opA_nxt[bitSel] = condT; // RULE17
          end
        end
        OP_BIT_AND_CARRY, OP_BIT_INV_AND_CARRY,
        OP_BIT_OR_CARRY, OP_BIT_INV_OR_CARRY: begin
          flags_nxt[`CDB_FL_C] = bitOut; // RULE15
        end
        OP_BIT_XOR_CARRY, OP_BIT_INV_XOR_CARRY: begin
          flags_nxt[`CDB_FL_C] = bitOut; // RULE16
        end
        default: begin
          flags_nxt = flags_r;
        end
      endcase
    end else if (stepping) begin
      opA_nxt = accNew[15:0]; // RULE8 RULE9
      if (wsz) begin
        high_nxt = accNew[31:16];
      end
      if (stepOvf) begin
        flags_nxt[`CDB_FL_O] = 1'b1; // RULE10
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic        hit;
  logic [31:0] rdMux;

  always_comb begin
    hit   = 1'b1;
    rdMux = 32'h0000_0000;
    if (paddr[7:6] == `CDB_MEM_SEL) begin
      rdMux = {16'h0000, mem[paddr[2 +: MAW]]};
    end else begin
      case (paddr)
        `CDB_OFS_CTRL:  rdMux = {10'h000, ctrl_r};
        `CDB_OFS_OPA:   rdMux = {16'h0000, opA_r};
        `CDB_OFS_OPB:   rdMux = {16'h0000, opB_r};
        `CDB_OFS_FLAGS: rdMux = {28'h0000000, flags_r};
        `CDB_OFS_HIGH:  rdMux = {16'h0000, high_r};
        `CDB_OFS_PC:    rdMux = {16'h0000, pc_r};
        `CDB_OFS_DISP:  rdMux = {24'h000000, disp_r};
        `CDB_OFS_MCAND: rdMux = {16'h0000, mcand_r};
        `CDB_OFS_MPLR:  rdMux = {16'h0000, mplr_r};
        `CDB_OFS_COUNT: rdMux = {16'h0000, count_r};
        `CDB_OFS_STAT:  rdMux = {28'h0000000, paused_r, taken_r,
                                 state_r != ST_IDLE, exec_r};
        default:        hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= apbSetup;
      pslverr <= apbSetup & ~hit;
      if (apbSetup && !pwrite) begin
        prdata <= rdMux;
      end
    end
  end

  function automatic logic wrAt(input logic [7:0] ofs);
    return apbWr && paddr == ofs;
  endfunction

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (apbWr && paddr[7:6] == `CDB_MEM_SEL) begin
      mem[paddr[2 +: MAW]] <= pwdata[15:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_r <= 22'h000000;
      exec_r <= 1'b0;
    end else begin
      exec_r <= 1'b0;
      if (wrAt(`CDB_OFS_CTRL) && state_r == ST_IDLE && !exec_r) begin
        ctrl_r <= pwdata[21:0];
        exec_r <= pwdata[`CDB_GO_BIT];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      opA_r   <= 16'h0000;
      high_r  <= 16'h0000;
      opB_r   <= 16'h0000;
      flags_r <= 4'h0;
      pc_r    <= 16'h0000;
      disp_r  <= 8'h00;
    end else begin
      opA_r   <= wrAt(`CDB_OFS_OPA)   ? pwdata[15:0] : opA_nxt;
      high_r  <= wrAt(`CDB_OFS_HIGH)  ? pwdata[15:0] : high_nxt;
      pc_r    <= wrAt(`CDB_OFS_PC)    ? pwdata[15:0] : pc_nxt;
      flags_r <= wrAt(`CDB_OFS_FLAGS) ? pwdata[3:0]  : flags_nxt;
      if (wrAt(`CDB_OFS_OPB)) begin
        opB_r <= pwdata[15:0];
      end
      if (wrAt(`CDB_OFS_DISP)) begin
        disp_r <= pwdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Sum-of-products sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      mcand_r <= 16'h0000;
      mplr_r  <= 16'h0000;
      count_r <= 16'h0000;
    end else begin
      if (wrAt(`CDB_OFS_MCAND)) begin
        mcand_r <= pwdata[15:0];
      end
      if (wrAt(`CDB_OFS_MPLR)) begin
        mplr_r <= pwdata[15:0];
      end
      if (wrAt(`CDB_OFS_COUNT)) begin
        count_r <= pwdata[15:0];
      end
      case (state_r)
        ST_IDLE: begin
          if (exec_r && op == OP_SUM_OF_PRODUCTS && count_r != 0) begin
            state_r <= ST_RUN; // RULE8
          end
        end
        ST_RUN: begin
          // Addition and decrement always complete before a stop.
          count_r <= count_r - 16'h0001; // RULE8 RULE12
          mcand_r <= mcand_r + 16'h0001;
          mplr_r  <= mplr_r + 16'h0001;
          if (stepOvf || stepLast || irqReq) begin
            state_r <= ST_END; // RULE10 RULE12
          end
        end
        ST_END: begin
          state_r <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      busy      <= 1'b0;
      ovfIrq    <= 1'b0;
      irqAccept <= 1'b0;
      taken_r   <= 1'b0;
      paused_r  <= 1'b0;
    end else begin
      busy      <= exec_r | (state_r != ST_IDLE);
      ovfIrq    <= stepping & stepOvf; // RULE11
      irqAccept <= stepping & irqReq & ~stepOvf & ~stepLast; // RULE12
      if (exec_r) begin
        taken_r  <= (op == OP_ADD_IMM_BRANCH ||
                     op == OP_SUB_IMM_BRANCH) && !resZero;
        paused_r <= 1'b0;
      end else if (stepping) begin
        paused_r <= irqReq & ~stepOvf & ~stepLast;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence sRunStep;
    state_r == ST_RUN;
  endsequence
  sequence sOvfStep;
    sRunStep ##0 stepOvf;
  endsequence
  sequence sIrqStep;
    sRunStep ##0 (irqReq && !stepOvf && !stepLast);
  endsequence

  chk_bcd_equal_zero: assert property ( // RULE1
    exec_r && op == OP_BCD_SUBTRACT && opA_r == opB_r |=>
    flags_r[`CDB_FL_Z] && flags_r[`CDB_FL_C] && !flags_r[`CDB_FL_S])
    else $error("bcd equal operands did not give zero");
  chk_bcd_borrow_nines: assert property ( // RULE2 RULE3 RULE21
    exec_r && op == OP_BCD_SUBTRACT_WITH_BORROW && wsz &&
    opA_r == opB_r && !flags_r[`CDB_FL_C] |=>
    opA_r == 16'h9999 && !flags_r[`CDB_FL_C] && flags_r[`CDB_FL_S])
    else $error("bcd borrow did not give 9999");
  chk_adj_branch_taken: assert property ( // RULE4 RULE7
    exec_r && op == OP_ADD_IMM_BRANCH && wsz &&
    opA_r + immS != 16'h0000 |=>
    taken_r && pc_r == $past(pc_r) + {{8{$past(disp_r[7])}},
    $past(disp_r)} + `CDB_BR_BIAS)
    else $error("add branch not taken to target");
  chk_sbj_eight_zero: assert property ( // RULE5 RULE6
    exec_r && op == OP_SUB_IMM_BRANCH && wsz &&
    imm == `CDB_SUB_EIGHT && opA_r == 16'h0008 |=>
    !taken_r && opA_r == 16'h0000 && $stable(pc_r))
    else $error("subtract eight did not reach zero");
  chk_sop_overflow: assert property ( // RULE10 RULE11
    sOvfStep |=> ovfIrq && flags_r[`CDB_FL_O] ##1 state_r == ST_IDLE)
    else $error("overflow did not stop the run");
  chk_sop_interrupt: assert property ( // RULE12
    sIrqStep |=> irqAccept && paused_r &&
    count_r == $past(count_r) - 16'h0001 && state_r == ST_END)
    else $error("interrupt taken without count step");
  chk_sext_word: assert property ( // RULE14
    exec_r && op == OP_SIGN_EXTEND && wsz |=>
    high_r == {16{opA_r[15]}} && $stable(opA_r))
    else $error("word sign extension wrong");
  chk_bit_xor: assert property ( // RULE16
    exec_r && op == OP_BIT_INV_XOR_CARRY |=>
    flags_r[`CDB_FL_C] ==
    ($past(flags_r[`CDB_FL_C]) ^ ~$past(curBit)))
    else $error("inverted xor into carry wrong");
  chk_cond_transfer: assert property ( // RULE17 RULE18
    exec_r && op == OP_CONDITIONAL_BIT_TRANSFER && toC &&
    cond == UNSIGNED_ABOVE |=> flags_r[`CDB_FL_C] ==
    ($past(flags_r[`CDB_FL_C]) & ~$past(flags_r[`CDB_FL_Z])))
    else $error("conditional carry transfer wrong");

endmodule

// file: tb/cdb_exec_tb_top.sv
// Self-checking bench for the decimal, bit and sum-of-products unit.
`timescale 1ns/10ps
`include "cdb_cfg.svh"
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  err_total++; $display("unexpected %s exp %h got %h", nm, ex, got); end end
module cdb_exec_tb_top;
  import cdb_pkg::*;
  typedef struct {
    cdb_op_e     op;
    logic        w;
    logic [3:0]  imm;
    logic [15:0] a, b;
    logic [3:0]  f;
    logic [7:0]  d;
    logic [15:0] xa;
    logic [3:0]  xf, m;
    logic [15:0] xpc;
  } cdb_row_s;
  logic        clock, rst_n, psel, penable, pwrite, irqReq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic        pready, pslverr, busy, ovfIrq, irqAccept, rerr;
  int          err_total, check_count, ovfSeen, acceptSeen;
  // ----------------------------------------------------------------------
  // Ordinary cases: operands, flags, displacement and expected results.
  // ----------------------------------------------------------------------
  cdb_row_s rows[19] = '{
    '{OP_BCD_SUBTRACT, 1'h0, 4'h0, 16'h1278, 16'h11, 4'h0, 8'h0,
      16'h1267, 4'h1, 4'h7, 16'h200},
    '{OP_BCD_SUBTRACT, 1'h1, 4'h0, 16'h1234, 16'h1111, 4'h0, 8'h0,
      16'h0123, 4'h1, 4'h7, 16'h200},
    '{OP_BCD_SUBTRACT, 1'h0, 4'h0, 16'h10, 16'h20, 4'h1, 8'h0,
      16'h90, 4'h4, 4'h7, 16'h200},
    '{OP_BCD_SUBTRACT, 1'h0, 4'h0, 16'h45, 16'h45, 4'h0, 8'h0,
      16'h0, 4'h3, 4'h7, 16'h200},
    '{OP_BCD_SUBTRACT_WITH_BORROW, 1'h0, 4'h0, 16'h50, 16'h25, 4'h0, 8'h0,
      16'h24, 4'h1, 4'h7, 16'h200},
    '{OP_ADD_IMM_BRANCH, 1'h1, 4'hf, 16'h5, 16'h0, 4'h0, 8'h10,
      16'h4, 4'h0, 4'h0, 16'h212},
    '{OP_ADD_IMM_BRANCH, 1'h1, 4'hf, 16'h1, 16'h0, 4'h0, 8'h10,
      16'h0, 4'h0, 4'h0, 16'h200},
    '{OP_ADD_IMM_BRANCH, 1'h1, 4'h8, 16'ha, 16'h0, 4'h0, 8'h7f,
      16'h2, 4'h0, 4'h0, 16'h281},
    '{OP_SUB_IMM_BRANCH, 1'h1, 4'h8, 16'h9, 16'h0, 4'h0, 8'h80,
      16'h1, 4'h0, 4'h0, 16'h182},
    '{OP_SIGN_EXTEND, 1'h0, 4'h0, 16'h12f0, 16'h0, 4'h0, 8'h0,
      16'hfff0, 4'h0, 4'h0, 16'h200},
    '{OP_BIT_AND_CARRY, 1'h0, 4'h0, 16'h0, 16'h8000, 4'h1, 8'h0,
      16'h0, 4'h1, 4'h1, 16'h200},
    '{OP_BIT_INV_AND_CARRY, 1'h0, 4'h0, 16'h0, 16'h8000, 4'h1, 8'h0,
      16'h0, 4'h0, 4'h1, 16'h200},
    '{OP_BIT_OR_CARRY, 1'h0, 4'h0, 16'h0, 16'h8000, 4'h0, 8'h0,
      16'h0, 4'h1, 4'h1, 16'h200},
    '{OP_BIT_INV_OR_CARRY, 1'h0, 4'h0, 16'h0, 16'h0, 4'h0, 8'h0,
      16'h0, 4'h1, 4'h1, 16'h200},
    '{OP_BIT_XOR_CARRY, 1'h0, 4'h0, 16'h0, 16'h8000, 4'h1, 8'h0,
      16'h0, 4'h0, 4'h1, 16'h200},
    '{OP_BIT_INV_XOR_CARRY, 1'h0, 4'h0, 16'h0, 16'h8000, 4'h1, 8'h0,
      16'h0, 4'h1, 4'h1, 16'h200},
    '{OP_CONDITIONAL_BIT_TRANSFER, 1'h0, 4'h0, 16'h0, 16'h0, 4'h1, 8'h0,
      16'h8000, 4'h1, 4'hf, 16'h200},
    '{OP_BCD_SUBTRACT_WITH_BORROW, 1'h1, 4'h0, 16'h1234, 16'h1234, 4'h0,
      8'h0, 16'h9999, 4'h4, 4'h7, 16'h200},
    '{OP_SUB_IMM_BRANCH, 1'h1, 4'h8, 16'h8, 16'h0, 4'h0, 8'h10,
      16'h0, 4'h0, 4'h0, 16'h200}};
  logic [15:0] memv[16] = '{16'h2, 16'h3, 16'hff, 16'h0, 16'h0, 16'h0,
    16'h0, 16'h0, 16'h5, 16'h4, 16'h7, 16'h0, 16'h7f, 16'h7f, 16'h7f,
    16'h7f};
  cdb_exec u_dut (.clock(clock), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .irqReq(irqReq), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .busy(busy), .ovfIrq(ovfIrq), .irqAccept(irqAccept));
  initial clock = 1'b0;
  always #50 clock = ~clock;
  always @(posedge clock) begin
    if (ovfIrq === 1'b1) ovfSeen++;
    if (irqAccept === 1'b1) acceptSeen++;
  end
  // ----------------------------------------------------------------------
  // Bus, operation and verdict tasks.
  // ----------------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) err_total++;
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [31:0] c);
    int n;
    apb(1'b1, `CDB_OFS_CTRL, c);
    repeat (2) @(posedge clock);
    `CHK("busy", 1'b1, busy)
    n = 0;
    while (busy !== 1'b0 && n < 100) begin
      @(posedge clock);
      n++;
    end
    if (n >= 100) err_total++;
  endtask
  task automatic sop(input logic [31:0] p, q, cnt);
    apb(1'b1, `CDB_OFS_OPA, 32'h0);
    apb(1'b1, `CDB_OFS_MCAND, p);
    apb(1'b1, `CDB_OFS_MPLR, q);
    apb(1'b1, `CDB_OFS_COUNT, cnt);
  endtask
  task automatic stop_test();
    if (err_total == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  function automatic logic cnd(input logic [3:0] k, input logic [3:0] f);
    case (k)
      4'h0: return f[0];
      4'h1: return f[0] & ~f[1];
      4'h2: return f[1];
      4'h3: return f[2];
      4'h4: return f[1] | (f[2] ^ f[3]);
      4'h5: return f[3];
      4'h6: return ~(f[2] ^ f[3]);
      4'h7: return ~f[0];
      4'h8: return ~f[0] | f[1];
      4'h9: return ~f[1];
      4'ha: return ~f[2];
      4'hb: return ~(f[2] ^ f[3]) & ~f[1];
      4'hc: return ~f[3];
      default: return f[2] ^ f[3];
    endcase
  endfunction
  initial begin
    repeat (30000) @(posedge clock);
    err_total++;
    stop_test();
  end
  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, irqReq, paddr, pwdata} = '0;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, `CDB_OFS_FLAGS, 32'h0);
    `CHK("reset flags", 32'h0, rdat)
    apb(1'b0, 8'h30, 32'h0);
    `CHK("unmapped err", 1'b1, rerr)
    foreach (rows[i]) begin
      apb(1'b1, `CDB_OFS_OPA, {16'h0, rows[i].a});
      apb(1'b1, `CDB_OFS_OPB, {16'h0, rows[i].b});
      apb(1'b1, `CDB_OFS_FLAGS, {28'h0, rows[i].f});
      apb(1'b1, `CDB_OFS_PC, 32'h200);
      apb(1'b1, `CDB_OFS_DISP, {24'h0, rows[i].d});
      run(32'h800f0000 | {20'h0, rows[i].imm, 3'h0, rows[i].w, rows[i].op});
      apb(1'b0, `CDB_OFS_OPA, 32'h0);
      `CHK("result", {16'h0, rows[i].xa}, rdat)
      apb(1'b0, `CDB_OFS_FLAGS, 32'h0);
      `CHK("flags", rows[i].xf & rows[i].m, rdat[3:0] & rows[i].m)
      apb(1'b0, `CDB_OFS_PC, 32'h0);
      `CHK("pc", {16'h0, rows[i].xpc}, rdat)
    end
    for (int k = 0; k < 14; k++) begin
      for (int f = 0; f < 16; f++) begin
        apb(1'b1, `CDB_OFS_FLAGS, 32'(f));
        run(32'h800f0020 | 32'(k << 12) | 32'(OP_CONDITIONAL_BIT_TRANSFER));
        apb(1'b0, `CDB_OFS_FLAGS, 32'h0);
        `CHK("cond", {3'(f >> 1), cnd(4'(k), 4'(f))}, rdat[3:0])
      end
    end
    apb(1'b1, `CDB_OFS_OPA, 32'h8001);
    run(32'h80000015);
    apb(1'b0, `CDB_OFS_HIGH, 32'h0);
    `CHK("sext high", 32'hffff, rdat)
    foreach (memv[i]) apb(1'b1, 8'h40 + 8'(4 * i), {16'h0, memv[i]});
    apb(1'b1, `CDB_OFS_FLAGS, 32'h8);
    sop(32'h0, 32'h8, 32'h3);
    run(32'h80000004);
    apb(1'b0, `CDB_OFS_OPA, 32'h0);
    `CHK("sum", 32'hf, rdat)
    apb(1'b0, `CDB_OFS_MCAND, 32'h0);
    `CHK("pointer", 32'h3, rdat)
    apb(1'b0, `CDB_OFS_FLAGS, 32'h0);
    `CHK("no overflow", 1'b0, rdat[3])
    sop(32'hc, 32'hc, 32'h4);
    run(32'h80000004);
    apb(1'b0, `CDB_OFS_OPA, 32'h0);
    `CHK("wrapped sum", 32'hbd03, rdat)
    apb(1'b0, `CDB_OFS_COUNT, 32'h0);
    `CHK("count at overflow", 32'h1, rdat)
    apb(1'b0, `CDB_OFS_FLAGS, 32'h0);
    `CHK("overflow flag", 1'b1, rdat[3])
    `CHK("overflow pulses", 1, ovfSeen)
    sop(32'h0, 32'h8, 32'h3);
    irqReq <= 1'b1;
    run(32'h80000004);
    irqReq <= 1'b0;
    `CHK("accept pulses", 1, acceptSeen)
    apb(1'b0, `CDB_OFS_COUNT, 32'h0);
    `CHK("count at pause", 32'h2, rdat)
    apb(1'b0, `CDB_OFS_OPA, 32'h0);
    `CHK("sum at pause", 32'ha, rdat)
    run(32'h80000004);
    apb(1'b0, `CDB_OFS_OPA, 32'h0);
    `CHK("resumed sum", 32'hf, rdat)
    sop(32'h1, 32'h9, 32'h3);
    apb(1'b1, `CDB_OFS_CTRL, 32'h80000004);
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, `CDB_OFS_MCAND, 32'h0);
    `CHK("pointer after reset", 32'h0, rdat)
    `CHK("busy after reset", 1'b0, busy)
    stop_test();
  end
endmodule
